/* File: hw/bad_pkg.sv */
// shared constants and types for the byte alu operand datapath
package bad_pkg;
    localparam int unsigned bad_clk_mhz = 250;
    localparam int unsigned bad_instr_ns = 250;
    localparam int unsigned bad_instr_cycles =
        (bad_instr_ns * bad_clk_mhz) / 1000;
    localparam int unsigned bad_ws_depth = 256;
    localparam logic [7:0] bad_reg_reset = 8'h00;
    localparam logic [3:0] bad_cycle_last = 4'h0;

    // operation codes
    typedef enum logic [2:0]
    {
        bad_op_move,
        bad_op_add,
        bad_op_and,
        bad_op_xor,
        bad_op_xmit
    } bad_op_t;

    // operand location kinds
    typedef enum logic [1:0]
    {
        bad_loc_reg,
        bad_loc_ws,
        bad_loc_iv
    } bad_loc_t;

    // register file selectors
    localparam logic [2:0] bad_sel_aux = 3'h0;
    localparam logic [2:0] bad_sel_gp1 = 3'h1;
    localparam logic [2:0] bad_sel_gp6 = 3'h6;
    localparam logic [2:0] bad_sel_carry = 3'h7;
    localparam logic [2:0] bad_sel_rbank = 3'h2;
    localparam logic [2:0] bad_sel_lbank = 3'h3;

    // one decoded instruction
    typedef struct packed
    {
        bad_op_t op;
        bad_loc_t src_loc;
        logic [2:0] src_reg;
        logic [2:0] rot;
        logic [2:0] src_pos;
        logic [2:0] src_len;
        bad_loc_t dst_loc;
        logic [2:0] dst_reg;
        logic [2:0] dst_pos;
        logic [2:0] dst_len;
        logic [7:0] literal;
    } bad_instr_t;
endpackage

/* File: hw/bad_datapath.sv */
// byte alu operand datapath: copy, add, and, xor, literal load
`timescale 1ns/1ps
`default_nettype none

module bad_datapath
    import bad_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic instr_valid_i,
    input var bad_instr_t instr_i,
    input wire logic [7:0] iv_in_i,
    output logic instr_ready_o,
    output logic [7:0] iv_addr_o,
    output logic [7:0] iv_out_o,
    output logic iv_wr_o,
    output logic [7:0] ws_addr_o,
    output logic [7:0] result_o,
    output logic carry_flag_o
);
    // register file: aux, general regs, bank address regs, carry in slot 7
    logic [7:0] regs [0:6];
    logic [7:0] next_regs [0:6];
    logic carry_flag;
    logic next_carry_flag;
    logic [7:0] working_storage [0:bad_ws_depth-1];
    logic [7:0] iv_out;
    logic [7:0] next_iv_out;
    logic iv_wr;
    logic next_iv_wr;
    logic [7:0] result;
    logic [7:0] next_result;
    logic ws_we;
    logic [7:0] ws_wdata;

    // iv input passes three flops; change taken once stages two and three agree
    logic [7:0] iv_s1;
    logic [7:0] iv_s2;
    logic [7:0] iv_s3;
    logic [7:0] iv_stable;
    logic [7:0] next_iv_stable;

    logic [7:0] src_raw;
    logic [7:0] src_field;
    logic [7:0] rotated;
    logic [7:0] alu;
    logic [8:0] sum;
    logic [7:0] field_mask;
    logic [7:0] dst_old;
    logic [7:0] merged;

    // every instruction is one clock; no stall possible
    // ready stays tied high so a sequencer can issue back to back
    // bank address registers drive the address pins straight from flops
    assign instr_ready_o = 1'b1;
    assign ws_addr_o = regs[bad_sel_rbank];
    assign iv_addr_o = regs[bad_sel_lbank];
    assign iv_out_o = iv_out;
    assign iv_wr_o = iv_wr;
    assign result_o = result;
    assign carry_flag_o = carry_flag;

    // pin synchroniser and agreement filter
    // a byte that is still settling across bits is held back until two
    // samples agree, so a source read never mixes old and new bits;
    // the cost is about four cycles of input latency
    always_comb
    begin
        next_iv_stable = (iv_s2 == iv_s3) ? iv_s3 : iv_stable;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            iv_s1 <= bad_reg_reset;
            iv_s2 <= bad_reg_reset;
            iv_s3 <= bad_reg_reset;
            iv_stable <= bad_reg_reset;
        end
        else
        begin
            iv_s1 <= iv_in_i;
            iv_s2 <= iv_s1;
            iv_s3 <= iv_s2;
            iv_stable <= next_iv_stable;
        end
    end

    // source fetch, rotate, field extract and alu
    always_comb
    begin
        unique case (instr_i.src_loc)
            bad_loc_ws: src_raw = working_storage[regs[bad_sel_rbank]];
            bad_loc_iv: src_raw = iv_stable;
            default:
            begin
                if (instr_i.src_reg == bad_sel_carry)
                    src_raw = {7'h00, carry_flag};
                else
                    src_raw = regs[instr_i.src_reg];
            end
        endcase
        // rotate a copy only; the source register is not written back
        rotated = (src_raw >> instr_i.rot) |
                  (src_raw << (4'h8 - {1'b0, instr_i.rot}));
        // field source: right-justify the chosen bits
        field_mask = 8'hff >> (3'h7 - instr_i.src_len);
        if (instr_i.src_loc == bad_loc_reg)
            src_field = rotated;
        else
            src_field = (src_raw >> instr_i.src_pos) & field_mask;
        sum = {1'b0, src_field} + {1'b0, regs[bad_sel_aux]};
        unique case (instr_i.op)
            bad_op_add: alu = sum[7:0];
            bad_op_and: alu = src_field & regs[bad_sel_aux];
            bad_op_xor: alu = src_field ^ regs[bad_sel_aux];
            bad_op_xmit: alu = instr_i.literal;
            default: alu = src_field;
        endcase
    end

    // destination merge: only the named field of a byte changes
    // register destinations always take the whole byte; field merge is
    // only for storage and port bytes, which is a read-modify-write
    // done within the one cycle
    always_comb
    begin
        logic [7:0] dmask;
        dmask = (8'hff >> (3'h7 - instr_i.dst_len)) << instr_i.dst_pos;
        unique case (instr_i.dst_loc)
            bad_loc_ws: dst_old = working_storage[regs[bad_sel_rbank]];
            bad_loc_iv: dst_old = iv_out;
            default: dst_old = bad_reg_reset;
        endcase
        if (instr_i.dst_loc == bad_loc_reg)
            merged = alu;
        else
            merged = (dst_old & ~dmask) | ((alu << instr_i.dst_pos) & dmask);
    end

    // next state for registers, carry, iv latch and storage write
    // carry slot is read only, so a write to it is quietly dropped
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            next_regs[i] = regs[i];
        next_carry_flag = carry_flag;
        next_iv_out = iv_out;
        next_iv_wr = 1'b0;
        next_result = result;
        ws_we = 1'b0;
        ws_wdata = merged;
        if (instr_valid_i)
        begin
            next_result = merged;
            if (instr_i.op == bad_op_add)
                next_carry_flag = sum[8];
            unique case (instr_i.dst_loc)
                bad_loc_ws: ws_we = 1'b1;
                bad_loc_iv:
                begin
                    next_iv_out = merged;
                    next_iv_wr = 1'b1;
                end
                default:
                begin
                    // aux only changes when named as the destination
                    if (instr_i.dst_reg != bad_sel_carry)
                        next_regs[instr_i.dst_reg] = merged;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 7; i++)
                regs[i] <= bad_reg_reset;
            carry_flag <= 1'b0;
            iv_out <= bad_reg_reset;
            iv_wr <= 1'b0;
            result <= bad_reg_reset;
        end
        else
        begin
            for (int i = 0; i < 7; i++)
                regs[i] <= next_regs[i];
            carry_flag <= next_carry_flag;
            iv_out <= next_iv_out;
            iv_wr <= next_iv_wr;
            result <= next_result;
        end
    end

    // storage array has no reset; software must initialise it
    always_ff @(posedge sys_clk_i)
    begin
        if (ws_we)
            working_storage[regs[bad_sel_rbank]] <= ws_wdata;
    end
endmodule

`default_nettype wire

/* File: tb/bad_sva.sv */
// port assertions for the byte alu operand datapath
`timescale 1ns/1ps
`default_nettype none
module bad_sva
    import bad_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic instr_valid_i,
    input var bad_instr_t instr_i,
    input wire logic instr_ready_o,
    input wire logic [7:0] iv_addr_o,
    input wire logic [7:0] iv_out_o,
    input wire logic iv_wr_o,
    input wire logic [7:0] ws_addr_o,
    input wire logic [7:0] result_o,
    input wire logic carry_flag_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // a literal load taken at this edge
    sequence xm;
        instr_valid_i && instr_i.op == bad_op_xmit;
    endsequence
    ready_on_a: assert property (instr_ready_o)
        else $error("not ready");
    rbank_lit_a: assert property (xm ##0 instr_i.dst_reg == bad_sel_rbank
        && instr_i.dst_loc == bad_loc_reg |=> ws_addr_o == $past(instr_i.literal))
        else $error("ws address");
    lbank_lit_a: assert property (xm ##0 instr_i.dst_reg == bad_sel_lbank
        && instr_i.dst_loc == bad_loc_reg |=> iv_addr_o == $past(instr_i.literal))
        else $error("iv address");
    reg_lit_a: assert property (xm ##0 instr_i.dst_reg != bad_sel_carry
        && instr_i.dst_loc == bad_loc_reg |=> result_o == $past(instr_i.literal))
        else $error("literal");
    iv_lit_a: assert property (xm ##0 instr_i.dst_loc == bad_loc_iv
        && instr_i.dst_len == 3'h7 && instr_i.dst_pos == 3'h0
        |=> iv_out_o == $past(instr_i.literal))
        else $error("iv literal");
    iv_strobe_a: assert property (iv_wr_o == ($past(instr_valid_i)
        && $past(instr_i.dst_loc) == bad_loc_iv)) else $error("iv strobe");
    iv_hold_a: assert property ($changed(iv_out_o) |-> iv_wr_o)
        else $error("iv changed");
    carry_hold_a: assert property ($changed(carry_flag_o) |->
        $past(instr_valid_i) && $past(instr_i.op) == bad_op_add)
        else $error("carry changed");
endmodule
bind bad_datapath bad_sva u_sva (.sys_clk_i, .rst_b_i, .instr_valid_i,
    .instr_i, .instr_ready_o, .iv_addr_o, .iv_out_o, .iv_wr_o, .ws_addr_o,
    .result_o, .carry_flag_o);
`default_nettype wire

/* File: tb/bad_iv_dev.sv */
// interface vector port model: one latched byte read back on the input
`timescale 1ns/1ps
`default_nettype none
module bad_iv_dev
(
    input wire logic sys_clk_i,
    input wire logic [7:0] iv_out_i,
    input wire logic iv_wr_i,
    output logic [7:0] iv_in_o
);
    logic [7:0] held = 8'h5a;
    // latch on the write strobe; preset so reads never see unknowns
    always @(posedge sys_clk_i)
        if (iv_wr_i) held <= iv_out_i;
    assign iv_in_o = held;
endmodule
`default_nettype wire

/* File: tb/bad_datapath_tb_top.sv */
// self-checking bench for the byte alu operand datapath
`timescale 1ns/1ps
`default_nettype none
module bad_datapath_tb_top
    import bad_pkg::*;
;
    logic sys_clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic instr_valid_i = 1'h0;
    bad_instr_t instr_i = '0;
    logic [7:0] iv_in_i, iv_addr_o, iv_out_o, ws_addr_o, result_o;
    logic instr_ready_o, iv_wr_o, carry_flag_o;
    int n_mismatch = 0;
    int checks_done = 0;
    bad_datapath u_dut (.sys_clk_i, .rst_b_i, .instr_valid_i, .instr_i,
        .iv_in_i, .instr_ready_o, .iv_addr_o, .iv_out_o, .iv_wr_o,
        .ws_addr_o, .result_o, .carry_flag_o);
    bad_iv_dev u_iv (.sys_clk_i, .iv_out_i(iv_out_o), .iv_wr_i(iv_wr_o),
        .iv_in_o(iv_in_i));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("unexpected %s exp %h got %h", nm, exp, got);
    endtask
    // one instruction per edge; consecutive calls run back to back
    task automatic go(bad_op_t op, logic [2:0] sr, logic [2:0] rot,
        bad_loc_t dl, logic [2:0] dr, logic [7:0] lit,
        bad_loc_t sl = bad_loc_reg);
        @(posedge sys_clk_i);
        instr_valid_i <= 1'h1;
        instr_i <= '{op, sl, sr, rot, 3'h0, 3'h7, dl, dr, 3'h0, 3'h7, lit};
    endtask
    task automatic xm(logic [2:0] dr, logic [7:0] lit);
        go(bad_op_xmit, 3'h0, 3'h0, bad_loc_reg, dr, lit);
    endtask
    // the last instruction's results are settled just after this edge
    task automatic done();
        @(posedge sys_clk_i);
        instr_valid_i <= 1'h0;
        #1;
    endtask
    task automatic t_lit();
        xm(bad_sel_rbank, 8'h33);
        xm(bad_sel_lbank, 8'h07);
        xm(bad_sel_gp1, 8'ha5);
        done();
        chk("ws_addr", 8'h33, ws_addr_o);
        chk("iv_addr", 8'h07, iv_addr_o);
        chk("result", 8'ha5, result_o);
    endtask
    // mask onto the port, then complement; the port byte must stand
    task automatic t_logic();
        xm(bad_sel_aux, 8'h0f);
        go(bad_op_and, bad_sel_gp1, 3'h0, bad_loc_iv, 3'h0, 8'h00);
        xm(bad_sel_aux, 8'hff);
        go(bad_op_xor, bad_sel_gp1, 3'h0, bad_loc_reg, 3'h4, 8'h00);
        done();
        chk("iv_out", 8'ha5 & 8'h0f, iv_out_o);
        chk("xor", ~8'ha5, result_o);
    endtask
    // rotate keeps the source; the carry reads back; aux survives moves
    task automatic t_arith();
        logic [7:0] s = 8'ha5;
        go(bad_op_move, bad_sel_gp1, 3'h3, bad_loc_reg, 3'h5, 8'h00);
        done();
        chk("rotated", {s[2:0], s[7:3]}, result_o);
        xm(bad_sel_aux, 8'hf0);
        go(bad_op_add, bad_sel_gp1, 3'h0, bad_loc_reg, 3'h4, 8'h00);
        go(bad_op_move, bad_sel_carry, 3'h0, bad_loc_reg, 3'h5, 8'h00);
        done();
        chk("carry", 8'h01, result_o);
        go(bad_op_add, 3'h4, 3'h0, bad_loc_reg, 3'h6, 8'h00);
        done();
        chk("sum", s + 8'hf0 + 8'hf0, result_o);
        chk("carry flag", 8'h01, {7'h00, carry_flag_o});
    endtask
    // storage bits 5..2 into port bits 7..4; low port nibble must stand
    task automatic t_field();
        @(posedge sys_clk_i);
        instr_valid_i <= 1'h1;
        instr_i <= '{bad_op_move, bad_loc_ws, 3'h0, 3'h0, 3'h2, 3'h3,
            bad_loc_iv, 3'h0, 3'h4, 3'h3, 8'h00};
        done();
        chk("field", 8'hf5, iv_out_o);
        chk("iv_wr", 8'h01, {7'h00, iv_wr_o});
        @(posedge sys_clk_i);
        #1;
        chk("iv_wr end", 8'h00, {7'h00, iv_wr_o});
    endtask
    // storage and port bytes as copy sources
    task automatic t_store();
        go(bad_op_xmit, 3'h0, 3'h0, bad_loc_ws, 3'h0, 8'h3c);
        xm(bad_sel_rbank, 8'h34);
        go(bad_op_xmit, 3'h0, 3'h0, bad_loc_ws, 3'h0, 8'hc3);
        xm(bad_sel_rbank, 8'h33);
        go(bad_op_move, 3'h0, 3'h0, bad_loc_reg, 3'h1, 8'h00, bad_loc_ws);
        done();
        chk("ws read", 8'h3c, result_o);
        go(bad_op_move, 3'h0, 3'h0, bad_loc_reg, 3'h6, 8'h00, bad_loc_iv);
        done();
        chk("iv read", 8'ha5 & 8'h0f, result_o);
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'h1;
        t_lit();
        t_logic();
        t_arith();
        t_store();
        t_field();
        wrap_up();
    end
    // hang guard, far beyond the forty or so cycles the run needs
    initial
    begin
        repeat (2000) @(posedge sys_clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire
